// file: inc/rme_defs.svh
`ifndef RME_DEFS_SVH
`define RME_DEFS_SVH

// register byte offsets on the bus
`define RME_OFS_MODE        8'h00
`define RME_OFS_CTRL        8'h04
`define RME_OFS_KEYMASK     8'h08
`define RME_OFS_STATUS      8'h0C

// mode readback field positions and fixed bits
`define RME_MODE_EXP_BIT    7
`define RME_MODE_FIXED      5'b1_1001
`define RME_MODE_SINGLE     2'b11

// control register fields
`define RME_CTRL_NMI_EDGE   0
`define RME_CTRL_WDT_NMI    1
`define RME_CTRL_WDT_RST    2
`define RME_CTRL_SENSE_LSB  8
`define RME_CTRL_EN_LSB     16
`define RME_CTRL_RESET      32'h0000_0000
`define RME_KEYMASK_RESET   8'hFF

// status register fields
`define RME_ST_NMI          0
`define RME_ST_IRQ_LSB      1
`define RME_ST_WDT          9
`define RME_ST_EXTRST       10
`define RME_ST_MODE_OK      11
`define RME_ST_MODE_LSB     12

// watchdog reset pulse length in system clocks
`define RME_WDT_RST_CYCLES  10'd518

// source numbers handed to the core
`define RME_NUM_IRQ         8
`define RME_NUM_INT         26
`define RME_NUM_SRC         36
`define RME_RESET_VECTOR    16'h0000

`endif

// file: inc/rme_pkg.sv
package rme_pkg;

  // reset sequencer states
  typedef enum logic [1:0] {
    RS_HELD,
    RS_VECTOR,
    RS_FIRST,
    RS_RUN
  } rme_rst_state_t;

  // status from the core at instruction boundaries
  typedef struct packed {
    logic instr_end;
    logic ccr_op_end;
    logic seq_end;
    logic i_mask;
  } rme_core_stat_t;

  // commands to the core
  typedef struct packed {
    logic        core_reset_n;
    logic        reset_seq_start;
    logic        set_i_mask;
    logic        load_reset_vector;
    logic [15:0] vector_addr;
    logic        int_take;
    logic [5:0]  int_num;
  } rme_core_ctl_t;

endpackage

// file: hw/rme_exception_entry.sv
`include "rme_defs.svh"

// Operation
// - mode select bits return mode pin levels latched on each read; not writable
// - mode bits 6,5,2 read one, bits 4,3 read zero, writes ignored
// - bit 7 is expanded enable on flash variant only, else reads one
// - reset pin low or watchdog reset stops everything and initialises state
// - reset sequence starts on clock after pin release or watchdog pulse end
// - watchdog reset pulse lasts exactly 518 system clocks
// - reset sequence sets the interrupt mask bit to one
// - reset sequence loads program counter from vector address zero, then fetches
// - no interrupt, not even non-maskable, before first instruction completes
// - no interrupt detected at end of a condition-code manipulation instruction
// - interrupts detected only at instruction end or exception sequence end
// - accept nine external sources on pins plus 26 internal sources
// - non-maskable always accepted; others refused while mask bit is one
// - highest priority request served first, each with its own number
// - each external request line selects falling edge or low level
// - non-maskable input is edge detected with selectable edge
// - request line six is shared with eight individually maskable key inputs
// - watchdog overflow routes to non-maskable or ordinary overflow interrupt
// - mode pins: 01 and 10 expanded, 11 single chip, 00 invalid
// - edge select zero means falling edge, one means rising edge
module rme_exception_entry #(
  parameter bit FLASH_VARIANT = 1'b0
) (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [7:0]            haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic                  hready,
  input  wire logic [31:0]           hwdata,
  output logic [31:0]                hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire logic                  reset_pin_n,
  input  wire logic                  mode_pin_high,
  input  wire logic                  mode_pin_low,
  input  wire logic                  nmi_pin,
  input  wire logic [7:0]            irq_pin_n,
  input  wire logic [7:0]            key_inputs,
  input  wire logic [25:0]           int_src,
  input  wire logic                  wdt_overflow,
  input  wire rme_pkg::rme_core_stat_t core_stat,
  output rme_pkg::rme_core_ctl_t     core_ctl,
  output logic                       chip_reset_n
);

  // pin synchronisers, first stage read only by second
  logic [19:0] sync1_r;
  logic [19:0] sync2_r;
  wire  [19:0] pins_async = {
    key_inputs,
    irq_pin_n,
    nmi_pin,
    mode_pin_high,
    mode_pin_low,
    reset_pin_n
  };

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_r <= 20'h0_0000;
      sync2_r <= 20'h0_0000;
    end else begin
      sync1_r <= pins_async;
      sync2_r <= sync1_r;
    end
  end

  // synchronised pin fields, safe for edge detection
  wire       res_pin_s = sync2_r[0];
  wire [1:0] mode_s    = sync2_r[2:1];
  wire       nmi_s     = sync2_r[3];
  wire [7:0] irq_s     = sync2_r[11:4];
  wire [7:0] key_s     = sync2_r[19:12];

  // watchdog reset pulse generator, survives chip reset
  logic [9:0] wdt_cnt_r;
  logic       wdt_busy_r;
  logic       ext_rst_src_r;
  logic [31:0] ctrl_r;
  wire        wdt_rst_req = wdt_overflow & ctrl_r[`RME_CTRL_WDT_RST] & ~wdt_busy_r;
  wire        wdt_last    = wdt_busy_r & (wdt_cnt_r == `RME_WDT_RST_CYCLES - 10'd1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdt_cnt_r  <= 10'h000;
      wdt_busy_r <= 1'b0;
    end else if (wdt_rst_req) begin
      wdt_cnt_r  <= 10'h000;
      wdt_busy_r <= 1'b1;
    end else if (wdt_busy_r) begin
      wdt_cnt_r  <= wdt_cnt_r + 10'd1;
      wdt_busy_r <= ~wdt_last;
    end
  end

  // internal chip reset: pin low or watchdog pulse
  wire chip_rst = ~res_pin_s | wdt_busy_r;

  // reset cause: pin sets, watchdog clears
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_rst_src_r <= 1'b1;
    end else if (~res_pin_s) begin
      ext_rst_src_r <= 1'b1;
    end else if (wdt_rst_req) begin
      ext_rst_src_r <= 1'b0;
    end
  end

  // bus address phase decode
  logic       rd_pend_r;
  logic       wr_pend_r;
  logic [7:0] addr_r;
  logic [31:0] hrdata_r;
  logic       hreadyout_r;
  logic       hresp_r;
  wire        take      = hsel & hready & htrans[1];
  wire        take_rd   = take & ~hwrite;
  wire        take_wr   = take & hwrite;
  wire        sel_mode  = (addr_r == `RME_OFS_MODE);
  wire        sel_ctrl  = (addr_r == `RME_OFS_CTRL);
  wire        sel_keym  = (addr_r == `RME_OFS_KEYMASK);
  wire        sel_stat  = (addr_r == `RME_OFS_STATUS);
  wire        wr_mode   = wr_pend_r & sel_mode;
  wire        wr_ctrl   = wr_pend_r & sel_ctrl;
  wire        wr_keym   = wr_pend_r & sel_keym;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_pend_r <= 1'b0;
      wr_pend_r <= 1'b0;
      addr_r    <= 8'h00;
    end else begin
      rd_pend_r <= take_rd;
      wr_pend_r <= take_wr;
      addr_r    <= take ? haddr : addr_r;
    end
  end

  // mode select bits latched from the pins on each mode read
  logic [1:0] mode_sel_r;
  logic       exp_en_r;
  logic       exp_loaded_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_sel_r <= 2'b00;
    end else if (take_rd & (haddr == `RME_OFS_MODE)) begin
      mode_sel_r <= mode_s;
    end
  end

  // expanded enable: strap from the mode pins after reset, writable on flash part only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      exp_en_r     <= 1'b0;
      exp_loaded_r <= 1'b0;
    end else if (chip_rst) begin
      exp_loaded_r <= 1'b0;
    end else if (!exp_loaded_r) begin
      exp_en_r     <= (mode_s != `RME_MODE_SINGLE);
      exp_loaded_r <= 1'b1;
    end else if (wr_mode & FLASH_VARIANT) begin
      exp_en_r     <= hwdata[`RME_MODE_EXP_BIT];
    end
  end

  // writable control fields; the unused bits always read zero
  wire [31:0] ctrl_wr_val = {
    8'h00,
    hwdata[23:8],
    5'b0_0000,
    hwdata[2:0]
  };

  // control and key mask registers, chip reset clears control and sets the key mask to all ones
  logic [7:0] keymask_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r    <= `RME_CTRL_RESET;
      keymask_r <= `RME_KEYMASK_RESET;
    end else if (chip_rst) begin
      ctrl_r    <= `RME_CTRL_RESET;
      keymask_r <= `RME_KEYMASK_RESET;
    end else begin
      ctrl_r    <= wr_ctrl ? ctrl_wr_val : ctrl_r;
      keymask_r <= wr_keym ? hwdata[7:0] : keymask_r;
    end
  end

  // decoded control fields
  wire       nmi_edge_sel = ctrl_r[`RME_CTRL_NMI_EDGE];
  wire       wdt_to_nmi   = ctrl_r[`RME_CTRL_WDT_NMI];
  wire [7:0] irq_edge     = ctrl_r[`RME_CTRL_SENSE_LSB +: 8];
  wire [7:0] irq_en       = ctrl_r[`RME_CTRL_EN_LSB +: 8];

  // line six combines the pin with unmasked keys, all active low
  wire [7:0] irq_line_n;
  assign irq_line_n[5:0] = irq_s[5:0];
  assign irq_line_n[6]   = irq_s[6] & (&(key_s | keymask_r));
  assign irq_line_n[7]   = irq_s[7];

  // acceptance and the winning source
  logic        accept;
  logic [5:0]  win_num;
  logic        win_any;
  logic [7:0]  irq_prev_r;
  logic [7:0]  irq_pend_r;
  logic        nmi_prev_r;
  logic        nmi_pend_r;
  logic        wdt_pend_r;

  // edge or level sensing per external request line
  genvar gi;
  generate
    for (gi = 0; gi < `RME_NUM_IRQ; gi = gi + 1) begin : g_irq
      wire fall = irq_prev_r[gi] & ~irq_line_n[gi];
      wire clr  = accept & (win_num == 6'(gi + 1));
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          irq_prev_r[gi] <= 1'b1;
          irq_pend_r[gi] <= 1'b0;
        end else if (chip_rst) begin
          irq_prev_r[gi] <= 1'b1;
          irq_pend_r[gi] <= 1'b0;
        end else begin
          irq_prev_r[gi] <= irq_line_n[gi];
          irq_pend_r[gi] <= (fall & irq_edge[gi]) | (irq_pend_r[gi] & ~clr);
        end
      end
    end
  endgenerate

  // non-maskable edge detector and watchdog overflow latch; set wins over clear
  wire nmi_edge = nmi_edge_sel ? (~nmi_prev_r & nmi_s) : (nmi_prev_r & ~nmi_s);
  wire wdt_ovf  = wdt_overflow & ~ctrl_r[`RME_CTRL_WDT_RST];
  wire nmi_set  = nmi_edge | (wdt_ovf & wdt_to_nmi);
  wire wdt_set  = wdt_ovf & ~wdt_to_nmi;
  wire nmi_clr  = accept & (win_num == 6'd0);
  wire wdt_clr  = accept & (win_num == 6'(`RME_NUM_SRC - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nmi_prev_r <= 1'b1;
      nmi_pend_r <= 1'b0;
      wdt_pend_r <= 1'b0;
    end else if (chip_rst) begin
      nmi_prev_r <= nmi_s;
      nmi_pend_r <= 1'b0;
      wdt_pend_r <= 1'b0;
    end else begin
      nmi_prev_r <= nmi_s;
      nmi_pend_r <= nmi_set | (nmi_pend_r & ~nmi_clr);
      wdt_pend_r <= wdt_set | (wdt_pend_r & ~wdt_clr);
    end
  end

  // request vector: nmi, eight lines, internal sources, watchdog overflow
  // a line requests while its edge is pending or, in level mode, while held low
  wire [7:0]  irq_level = ~irq_edge & ~irq_line_n;
  wire [7:0]  irq_req   = irq_en & (irq_pend_r | irq_level);
  wire [35:0] req_all   = {
    wdt_pend_r,
    int_src,
    irq_req,
    nmi_pend_r
  };
  wire [35:0] req_ok   = req_all & {{35{~core_stat.i_mask}}, 1'b1};

  // lowest index wins, so nmi beats every other source
  always_comb begin
    win_num = 6'h00;
    win_any = 1'b0;
    for (int i = `RME_NUM_SRC - 1; i >= 0; i--) begin
      if (req_ok[i]) begin
        win_num = 6'(i);
        win_any = 1'b1;
      end
    end
  end

  // reset sequencer
  rme_pkg::rme_rst_state_t rst_state_r;
  rme_pkg::rme_rst_state_t rst_state_nxt;
  rme_pkg::rme_core_ctl_t  core_ctl_r;
  rme_pkg::rme_core_ctl_t  core_ctl_nxt;

  always_comb begin
    rst_state_nxt = rst_state_r;
    unique case (rst_state_r)
      rme_pkg::RS_HELD:   rst_state_nxt = rme_pkg::RS_VECTOR;
      rme_pkg::RS_VECTOR: rst_state_nxt = rme_pkg::RS_FIRST;
      rme_pkg::RS_FIRST:  rst_state_nxt = core_stat.instr_end ? rme_pkg::RS_RUN : rme_pkg::RS_FIRST;
      rme_pkg::RS_RUN:    rst_state_nxt = rme_pkg::RS_RUN;
    endcase
  end

  // boundary check: only at instruction or sequence end, never right after a ccr op
  wire boundary = (rst_state_r == rme_pkg::RS_RUN) ? (core_stat.instr_end | core_stat.seq_end)
                : (rst_state_r == rme_pkg::RS_FIRST) & core_stat.instr_end;
  assign accept = ~chip_rst & boundary & ~core_stat.ccr_op_end & win_any;

  // core commands, registered
  always_comb begin
    core_ctl_nxt                   = '0;
    core_ctl_nxt.core_reset_n      = ~chip_rst;
    core_ctl_nxt.vector_addr       = `RME_RESET_VECTOR;
    core_ctl_nxt.reset_seq_start   = ~chip_rst & (rst_state_r == rme_pkg::RS_HELD);
    core_ctl_nxt.set_i_mask        = ~chip_rst & (rst_state_r == rme_pkg::RS_HELD);
    core_ctl_nxt.load_reset_vector = ~chip_rst & (rst_state_r == rme_pkg::RS_VECTOR);
    core_ctl_nxt.int_take          = accept;
    core_ctl_nxt.int_num           = accept ? win_num : 6'h00;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_state_r  <= rme_pkg::RS_HELD;
      core_ctl_r   <= '0;
      chip_reset_n <= 1'b0;
    end else begin
      rst_state_r  <= chip_rst ? rme_pkg::RS_HELD : rst_state_nxt;
      core_ctl_r   <= core_ctl_nxt;
      chip_reset_n <= ~chip_rst;
    end
  end

  // command word to the core comes straight from its flop
  assign core_ctl = core_ctl_r;

  // read data: mode byte with fixed reserved bits and status word
  wire        exp_bit   = FLASH_VARIANT ? exp_en_r : 1'b1;
  wire [7:0]  mode_byte = {exp_bit, `RME_MODE_FIXED, mode_sel_r};
  wire        mode_ok   = (mode_s != 2'b00);
  wire [31:0] status_w  = {
    18'h0_0000,
    mode_s,        // live mode pins
    mode_ok,
    ext_rst_src_r, // one after a pin reset
    wdt_pend_r,
    irq_pend_r,
    nmi_pend_r
  };
  wire [31:0] rd_mux    = sel_mode ? {24'h00_0000, mode_byte} :
                          sel_ctrl ? ctrl_r :
                          sel_keym ? {24'h00_0000, keymask_r} :
                          sel_stat ? status_w : 32'h0000_0000;

  // one wait state on reads so a preceding write is seen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r    <= 32'h0000_0000;
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end else begin
      hrdata_r    <= (rd_pend_r & ~hreadyout_r) ? rd_mux : hrdata_r;
      hreadyout_r <= ~take_rd;
      hresp_r     <= 1'b0;
    end
  end

  // bus outputs come straight from their flops
  assign hrdata    = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp     = hresp_r;

endmodule // rme_exception_entry

// file: verification/rme_exception_entry_props.sv
module rme_exception_entry_props (
  input wire logic                    hclk,
  input wire logic                    hresetn,
  input wire logic                    hsel,
  input wire logic [1:0]              htrans,
  input wire logic                    hwrite,
  input wire logic                    hready,
  input wire logic                    hreadyout,
  input wire logic                    hresp,
  input wire rme_pkg::rme_core_stat_t core_stat,
  input wire rme_pkg::rme_core_ctl_t  core_ctl,
  input wire logic                    chip_reset_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic first_r;
  wire  req = hsel && hready && htrans[1];
  default clocking dc @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // set once the first instruction after a chip reset has ended
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) first_r <= 1'b0;
    else first_r <= chip_reset_n && (first_r || core_stat.instr_end);
  end
  // mask set, then vector fetch from address zero
  sequence s_entry;
    core_ctl.set_i_mask ##1 core_ctl.load_reset_vector && core_ctl.vector_addr == 16'h0000;
  endsequence
  a_read_wait: assert property (req && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_ready: assert property (req && hwrite |=> hreadyout)
    else $error("write stalled");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  a_reset_entry: assert property (core_ctl.reset_seq_start |-> s_entry)
    else $error("reset entry order wrong");
  a_entry_soon: assert property ($rose(chip_reset_n) |-> ##[0:3] core_ctl.reset_seq_start)
    else $error("reset sequence late");
  a_take_boundary: assert property (core_ctl.int_take |->
    ($past(core_stat.instr_end) || $past(core_stat.seq_end)) && !$past(core_stat.ccr_op_end))
    else $error("take off a boundary");
  a_mask_refuse: assert property (core_ctl.int_take && core_ctl.int_num != 6'd0 |-> !$past(core_stat.i_mask))
    else $error("masked take");
  a_reset_quiet: assert property (!chip_reset_n && !$past(chip_reset_n) |-> !core_ctl.int_take)
    else $error("take during reset");
  a_first_instr: assert property (core_ctl.int_take |-> first_r)
    else $error("take before first instruction");
endmodule // rme_exception_entry_props

// file: verification/rme_core_model.sv
module rme_core_model (
  input wire logic                   hclk,
  input wire rme_pkg::rme_core_ctl_t core_ctl,
  input wire logic                   ccr_hold,
  input wire logic                   mask_clr,
  output rme_pkg::rme_core_stat_t    core_stat
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt_r;
  logic [1:0] seq_r;
  logic       run_r;
  logic       imask_r;
  logic       clr_r;
  wire        ie = run_r && cnt_r == 3'd7;
  // one instruction per eight clocks once the vector is fetched; a toggle of mask_clr clears the mask
  always_ff @(posedge hclk) begin
    if (core_ctl.load_reset_vector) run_r <= 1'b1;
    else if (!core_ctl.core_reset_n) run_r <= 1'b0;
    cnt_r <= run_r ? cnt_r + 3'd1 : 3'd0;
    seq_r <= {seq_r[0], core_ctl.int_take};
    if (core_ctl.set_i_mask || core_ctl.int_take || !core_ctl.core_reset_n) imask_r <= 1'b1;
    else if (mask_clr != clr_r) imask_r <= 1'b0;
    clr_r <= mask_clr;
  end
  assign core_stat = {ie, ie && ccr_hold, seq_r[1], imask_r};
endmodule // rme_core_model

// file: verification/rme_exception_entry_tb.sv
module rme_exception_entry_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, wdt_overflow = 1'b0;
  logic        reset_pin_n = 1'b0, mode_pin_high = 1'b1, mode_pin_low = 1'b1, nmi_pin = 1'b1;
  logic        ccr_hold = 1'b0, mask_clr = 1'b0, hreadyout, hresp, chip_reset_n;
  logic [1:0]  htrans = 2'b00;
  logic [7:0]  haddr = 8'h00, irq_pin_n = 8'hff, key_inputs = 8'hff;
  logic [25:0] int_src = 26'h000_0000;
  logic [31:0] hwdata = 32'h0000_0000, hrdata, rd;
  wire logic   hready = hreadyout;
  rme_pkg::rme_core_stat_t core_stat;
  rme_pkg::rme_core_ctl_t  core_ctl;
  int          fails = 0, total_checks = 0, takes = 0, seed = 32'h97b6, n, l, s;
  int          exp_q[$];

  always #20 hclk = ~hclk;

  rme_exception_entry #(.FLASH_VARIANT(1'b0)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'b010), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .reset_pin_n(reset_pin_n), .mode_pin_high(mode_pin_high), .mode_pin_low(mode_pin_low),
    .nmi_pin(nmi_pin), .irq_pin_n(irq_pin_n), .key_inputs(key_inputs), .int_src(int_src),
    .wdt_overflow(wdt_overflow), .core_stat(core_stat), .core_ctl(core_ctl), .chip_reset_n(chip_reset_n));
  rme_core_model model (.hclk(hclk), .core_ctl(core_ctl), .ccr_hold(ccr_hold), .mask_clr(mask_clr),
    .core_stat(core_stat));

  // comparison, verdict and bounded waits
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task rdy_edge;
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 50) begin
        fails++;
        report_and_stop;
      end
      @(posedge hclk);
    end
  endtask
  // one single bus transfer: address phase, then data phase
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    rdy_edge;
    htrans <= 2'b00;
    hwdata <= d;
    rdy_edge;
    rd = hrdata;
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    check(rd & m, e);
  endtask
  task expect_take(input int num);
    int k;
    exp_q.push_back(num);
    k = takes;
    for (int i = 0; i < 300 && takes == k; i++) @(negedge hclk);
    if (takes == k) begin
      fails++;
      report_and_stop;
    end
    @(posedge hclk);
  endtask
  task quiet;
    int k;
    k = takes;
    repeat (40) @(posedge hclk);
    check(takes, k);
  endtask
  task pulse_wdt;
    wdt_overflow <= 1'b1;
    @(posedge hclk);
    wdt_overflow <= 1'b0;
  endtask

  // every accepted interrupt is compared with the queue of expected numbers
  always @(posedge hclk) begin
    if (core_ctl.int_take === 1'b1) begin
      takes++;
      check(core_ctl.int_num, exp_q.size() > 0 ? exp_q.pop_front() : 32'h0000_003f);
    end
  end

  // main sequence
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1; // reset pin stays low past the power-on release
    repeat (9) @(posedge hclk);
    reset_pin_n <= 1'b1;
    for (int i = 0; i < 20 && chip_reset_n !== 1'b1; i++) @(posedge hclk);
    check(chip_reset_n, 32'h0000_0001);
    nmi_pin <= 1'b0;
    expect_take(0);
    nmi_pin <= 1'b1;
    $display("test first instruction done");
    for (int i = 0; i < 4; i++) begin
      {mode_pin_high, mode_pin_low} <= 2'(i);
      repeat (3) @(posedge hclk);
      rdchk(8'h00, 32'hffff_ffff, 32'h0000_00e4 | i);
      rdchk(8'h0c, 32'h0000_3c00, {18'h0, 2'(i), i != 0, 11'h400});
    end
    bus(1'b1, 8'h00, 32'h0000_0000);
    rdchk(8'h00, 32'hffff_ffff, 32'h0000_00e7);
    rdchk(8'h04, 32'hffff_ffff, 32'h0000_0000);
    rdchk(8'h08, 32'h0000_00ff, 32'h0000_00ff);
    rdchk(8'h10, 32'hffff_ffff, 32'h0000_0000);
    $display("test mode readback done");
    l = {$random(seed)} % 8;
    s = {$random(seed)} % 26;
    bus(1'b1, 8'h04, 32'h00ff_0000);
    irq_pin_n[l] <= 1'b0;
    int_src[s] <= 1'b1;
    quiet;
    mask_clr <= ~mask_clr;
    expect_take(1 + l);
    irq_pin_n <= 8'hff;
    repeat (4) @(posedge hclk);
    mask_clr <= ~mask_clr;
    expect_take(9 + s);
    int_src <= 26'h000_0000;
    $display("test priority and mask done");
    bus(1'b1, 8'h04, 32'h00ff_ff00);
    irq_pin_n[l] <= 1'b0;
    repeat (4) @(posedge hclk);
    irq_pin_n[l] <= 1'b1;
    repeat (4) @(posedge hclk);
    rdchk(8'h0c, 32'h0000_01fe, 32'h0000_0002 << l);
    mask_clr <= ~mask_clr;
    expect_take(1 + l);
    rdchk(8'h0c, 32'h0000_01fe, 32'h0000_0000);
    $display("test edge sensing done");
    bus(1'b1, 8'h04, 32'h0000_0001);
    nmi_pin <= 1'b0;
    quiet;
    nmi_pin <= 1'b1;
    expect_take(0);
    ccr_hold <= 1'b1;
    nmi_pin <= 1'b0;
    repeat (4) @(posedge hclk);
    nmi_pin <= 1'b1;
    quiet;
    ccr_hold <= 1'b0;
    expect_take(0);
    $display("test edge and ccr block done");
    bus(1'b1, 8'h04, 32'h0040_0000);
    bus(1'b1, 8'h08, 32'h0000_00ef);
    key_inputs <= 8'hdf;
    mask_clr <= ~mask_clr;
    quiet;
    key_inputs <= 8'hef;
    expect_take(7);
    key_inputs <= 8'hff;
    bus(1'b1, 8'h04, 32'h0000_0002);
    pulse_wdt;
    expect_take(0);
    bus(1'b1, 8'h04, 32'h0000_0000);
    pulse_wdt;
    mask_clr <= ~mask_clr;
    expect_take(35);
    $display("test keys and watchdog routing done");
    bus(1'b1, 8'h04, 32'h0000_0004);
    pulse_wdt;
    n = 0;
    for (int i = 0; i < 700; i++) begin
      @(negedge hclk);
      if (chip_reset_n === 1'b0) n++;
    end
    check(n, 518);
    rdchk(8'h0c, 32'h0000_0400, 32'h0000_0000);
    rdchk(8'h04, 32'hffff_ffff, 32'h0000_0000);
    bus(1'b1, 8'h08, 32'h0000_0000);
    reset_pin_n <= 1'b0;
    repeat (10) @(posedge hclk);
    reset_pin_n <= 1'b1;
    repeat (10) @(posedge hclk);
    rdchk(8'h08, 32'h0000_00ff, 32'h0000_00ff);
    rdchk(8'h0c, 32'h0000_0400, 32'h0000_0400);
    $display("test resets done");
    reset_pin_n <= 1'b0;
    report_and_stop;
  end
endmodule // rme_exception_entry_tb

bind rme_exception_entry rme_exception_entry_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .core_stat(core_stat), .core_ctl(core_ctl), .chip_reset_n(chip_reset_n));
